/* rtl/crs_consts.svh */
// timing and reset constants for the compressor remote sequencer
// assumes a 100 MHz core clock and a 1 ms internal time base
`ifndef CRS_CONSTS_SVH
`define CRS_CONSTS_SVH

`define CRS_CLK_HZ 100000000
`define CRS_TICK_HZ 1000
`define CRS_MS_W 13
`define CRS_QW 9
`define CRS_QUAL_MS 300
`define CRS_INIT_MS 5000
`define CRS_SETTLE_MS 5000
`define CRS_BROWNOUT_MS 2000
`define CRS_ALARM_OFF_MS 2000
`define CRS_ALARM_ON_MS 500

`endif

/* rtl/crs_pkg.sv */
// types shared by the compressor remote sequencer
// constants live in crs_consts.svh
package crs_pkg;

    typedef enum logic [4:0] {
        CRS_ST_INIT = 5'h01,
        CRS_ST_IDLE = 5'h02,
        CRS_ST_SETTLE = 5'h04,
        CRS_ST_RUN = 5'h08,
        CRS_ST_PWRLOSS = 5'h10
    } crs_state_t;

    typedef struct packed {
        logic run_pulse;
        logic halt_hold;
        logic run_level;
        logic [1:0] cooler;
        logic fault;
        logic panel_reset;
        logic power_good;
    } crs_pins_t;

endpackage : crs_pkg

/* rtl/crs_top.sv */
// remote discrete-signal sequencer of a cryogenic compressor
// assumes all I_ pins other than clock and reset are asynchronous contacts,
// and that the logic stays powered through a mains dip (I_POWER_GOOD low)
//
// Functional notes
// - momentary start after pulse held over 0.3 s
// - momentary stop after halt released over 0.3 s
// - alternate mode follows run level command
// - running compressor follows each cooler command
// - no cooler acknowledge while compressor stopped
// - running acknowledge once compressor has started
// - alarm latched on fault, panel reset clears
// - alarm pulses 2 s off, 0.5 s on
// - cooler acknowledge once that channel started
// - alternate and cooler acknowledges follow commands within a few cycles, momentary ones just over 0.3 s
// - commands ignored, outputs other than alarm and O_MODE_ALTERNATE quiet 5 s after power-on
// - quick restart or dip delays acknowledge 5 s
// - momentary auto-restart after dip under 2 s
// - alternate restarts on recovery if level active
// - first command after power-up fixes mode
`timescale 1ns/1ps
`include "crs_consts.svh"

module crs_top #(
    parameter int unsigned TICK_CYC = `CRS_CLK_HZ / `CRS_TICK_HZ
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    // compressor commands from the equipment
    input wire logic I_RUN_REQUEST_PULSE,
    input wire logic I_HALT_REQUEST_HOLD,
    input wire logic I_RUN_LEVEL_COMMAND,
    input wire logic I_COOLER1_COMMAND,
    input wire logic I_COOLER2_COMMAND,
    // unit status
    input wire logic I_FAULT,
    input wire logic I_PANEL_RESET,
    input wire logic I_POWER_GOOD,
    // drives inside the unit
    output logic O_COMP_RUN,
    output logic O_COOLER1_RUN,
    output logic O_COOLER2_RUN,
    // answers to the equipment
    output logic O_RUNNING_ACK,
    output logic O_COOLER1_ACK,
    output logic O_COOLER2_ACK,
    output logic O_ALARM,
    // mode status
    output logic O_MODE_FIXED,
    output logic O_MODE_ALTERNATE
);

    localparam logic [`CRS_QW-1:0] QUAL = `CRS_QW'(`CRS_QUAL_MS);
    localparam logic [`CRS_QW-1:0] QUAL_OVER = `CRS_QW'(`CRS_QUAL_MS + 1);
    localparam logic [16:0] TICK_LAST = 17'(TICK_CYC - 1);

    // holds a count while act is high, advancing on ticks up to a ceiling
    function automatic logic [`CRS_QW-1:0] crs_count(input logic [`CRS_QW-1:0] c, input logic act,
                                                      input logic t, input logic [`CRS_QW-1:0] top);
        crs_count = c;
        if (!act) begin
            crs_count = '0;
        end else if (t && c != top) begin
            crs_count = c + `CRS_QW'(1);
        end
    endfunction : crs_count

    // input synchronisers
    crs_pkg::crs_pins_t pin_raw;
    crs_pkg::crs_pins_t pin_meta;
    crs_pkg::crs_pins_t pin;

    assign pin_raw = {I_RUN_REQUEST_PULSE, I_HALT_REQUEST_HOLD, I_RUN_LEVEL_COMMAND,
                      I_COOLER2_COMMAND, I_COOLER1_COMMAND, I_FAULT, I_PANEL_RESET, I_POWER_GOOD};

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            pin_meta <= '0;
            pin <= '0;
        end else begin
            pin_meta <= pin_raw;
            pin <= pin_meta;
        end
    end

    // 1 ms time base
    logic [16:0] tick_cnt;
    logic [16:0] next_tick_cnt;
    logic tick;
    logic next_tick;

    always_comb begin
        next_tick = (tick_cnt == TICK_LAST);
        next_tick_cnt = next_tick ? 17'h00000 : tick_cnt + 17'h00001;
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            tick_cnt <= 17'h00000;
            tick <= 1'b0;
        end else begin
            tick_cnt <= next_tick_cnt;
            tick <= next_tick;
        end
    end

    // command qualification
    crs_pkg::crs_state_t state;
    crs_pkg::crs_state_t next_state;
    logic [`CRS_QW-1:0] start_cnt;
    logic [`CRS_QW-1:0] stop_cnt;
    logic [`CRS_QW-1:0] since_stop;
    logic [`CRS_QW-1:0] next_start_cnt;
    logic [`CRS_QW-1:0] next_stop_cnt;
    logic [`CRS_QW-1:0] next_since_stop;
    logic start_q;
    logic stop_q;

    always_comb begin
        next_start_cnt = crs_count(start_cnt, pin.run_pulse, tick, QUAL_OVER);
        next_stop_cnt = crs_count(stop_cnt, !pin.halt_hold, tick, QUAL_OVER);
        next_since_stop = crs_count(since_stop, state != crs_pkg::CRS_ST_RUN, tick, QUAL);
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            start_cnt <= '0;
            stop_cnt <= '0;
            since_stop <= QUAL;
        end else begin
            start_cnt <= next_start_cnt;
            stop_cnt <= next_stop_cnt;
            since_stop <= next_since_stop;
        end
    end

    assign start_q = (start_cnt == QUAL_OVER);
    assign stop_q = (stop_cnt == QUAL_OVER);

    // alarm latch and pulses
    logic alarm_latch;
    logic next_alarm_latch;
    logic [`CRS_MS_W-1:0] alarm_tmr;
    logic [`CRS_MS_W-1:0] next_alarm_tmr;
    logic pg_prev;

    always_comb begin
        // a fault present in the clearing cycle keeps the latch set
        next_alarm_latch = pin.fault || (alarm_latch && !pin.panel_reset);
        next_alarm_tmr = alarm_tmr;
        if (pg_prev && !pin.power_good) begin
            next_alarm_tmr = `CRS_MS_W'(`CRS_ALARM_OFF_MS);
        end else if (!pg_prev && pin.power_good && state == crs_pkg::CRS_ST_INIT) begin
            next_alarm_tmr = `CRS_MS_W'(`CRS_ALARM_ON_MS);
        end else if (tick && alarm_tmr != '0) begin
            next_alarm_tmr = alarm_tmr - `CRS_MS_W'(1);
        end
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            alarm_latch <= 1'b0;
            alarm_tmr <= '0;
            pg_prev <= 1'b0;
        end else begin
            alarm_latch <= next_alarm_latch;
            alarm_tmr <= next_alarm_tmr;
            pg_prev <= pin.power_good;
        end
    end

    // sequencer
    logic [`CRS_MS_W-1:0] tmr;
    logic [`CRS_MS_W-1:0] next_tmr;
    logic mode_set;
    logic mode_alt;
    logic was_run;
    logic next_mode_set;
    logic next_mode_alt;
    logic next_was_run;
    logic run_cmd;
    logic stop_cmd;

    always_comb begin
        run_cmd = mode_alt ? pin.run_level : (start_q && pin.halt_hold);
        stop_cmd = mode_alt ? !pin.run_level : stop_q;
        next_state = state;
        next_tmr = tmr;
        next_mode_set = mode_set;
        next_mode_alt = mode_alt;
        next_was_run = was_run;
        if (tick && tmr != {`CRS_MS_W{1'b1}}) begin
            next_tmr = tmr + `CRS_MS_W'(1);
        end
        case (state)
            crs_pkg::CRS_ST_INIT: begin
                // a long outage lands here too, so mode is learnt afresh
                next_mode_set = 1'b0;
                if (!pin.power_good) begin
                    next_tmr = '0;
                end else if (tmr >= `CRS_MS_W'(`CRS_INIT_MS)) begin
                    next_state = crs_pkg::CRS_ST_IDLE;
                end
            end
            crs_pkg::CRS_ST_IDLE: begin
                next_tmr = '0;
                next_was_run = 1'b0;
                if (!pin.power_good) begin
                    next_state = crs_pkg::CRS_ST_PWRLOSS;
                end else if (!mode_set) begin
                    if (pin.run_level) begin
                        next_mode_set = 1'b1;
                        next_mode_alt = 1'b1;
                    end else if (start_q) begin
                        next_mode_set = 1'b1;
                        next_mode_alt = 1'b0;
                    end
                end else if (run_cmd && !alarm_latch) begin
                    // restart right after a stop waits for the pressure to settle
                    next_state = (since_stop < QUAL) ? crs_pkg::CRS_ST_SETTLE : crs_pkg::CRS_ST_RUN;
                end
            end
            crs_pkg::CRS_ST_SETTLE: begin
                if (!pin.power_good) begin
                    next_state = crs_pkg::CRS_ST_PWRLOSS;
                    next_tmr = '0;
                    next_was_run = 1'b1;
                end else if (stop_cmd || alarm_latch) begin
                    next_state = crs_pkg::CRS_ST_IDLE;
                end else if (tmr >= `CRS_MS_W'(`CRS_SETTLE_MS)) begin
                    next_state = crs_pkg::CRS_ST_RUN;
                end
            end
            crs_pkg::CRS_ST_RUN: begin
                next_tmr = '0;
                if (!pin.power_good) begin
                    next_state = crs_pkg::CRS_ST_PWRLOSS;
                    next_was_run = 1'b1;
                end else if (stop_cmd || alarm_latch) begin
                    next_state = crs_pkg::CRS_ST_IDLE;
                end
            end
            crs_pkg::CRS_ST_PWRLOSS: begin
                if (pin.power_good) begin
                    next_tmr = '0;
                    if (mode_set && (mode_alt ? pin.run_level : was_run) && !alarm_latch) begin
                        next_state = crs_pkg::CRS_ST_SETTLE;
                    end else begin
                        next_state = crs_pkg::CRS_ST_IDLE;
                    end
                end else if (tmr >= `CRS_MS_W'(`CRS_BROWNOUT_MS)) begin
                    next_state = crs_pkg::CRS_ST_INIT;
                    next_tmr = '0;
                end
            end
            default: begin
                next_state = crs_pkg::CRS_ST_INIT;
                next_tmr = '0;
            end
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            state <= crs_pkg::CRS_ST_INIT;
            tmr <= '0;
            mode_set <= 1'b0;
            mode_alt <= 1'b0;
            was_run <= 1'b0;
        end else begin
            state <= next_state;
            tmr <= next_tmr;
            mode_set <= next_mode_set;
            mode_alt <= next_mode_alt;
            was_run <= next_was_run;
        end
    end

    // output drives, all registered
    logic running;
    logic comp_run;
    logic run_ack;
    logic alarm;
    logic next_comp_run;
    logic next_run_ack;
    logic next_alarm;
    logic [1:0] cool_run;
    logic [1:0] cool_ack;

    assign running = (state == crs_pkg::CRS_ST_RUN);

    always_comb begin
        next_comp_run = running;
        next_run_ack = running && comp_run;
        next_alarm = alarm_latch || (alarm_tmr != '0);
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            comp_run <= 1'b0;
            run_ack <= 1'b0;
            alarm <= 1'b0;
        end else begin
            comp_run <= next_comp_run;
            run_ack <= next_run_ack;
            alarm <= next_alarm;
        end
    end

    for (genvar i = 0; i < 2; i++) begin : g_cooler
        logic next_run;
        logic next_ack;
        always_comb begin
            next_run = running && pin.cooler[i];
            next_ack = next_run && cool_run[i];
        end
        always_ff @(posedge I_CLK or negedge I_ARST_N) begin
            if (!I_ARST_N) begin
                cool_run[i] <= 1'b0;
                cool_ack[i] <= 1'b0;
            end else begin
                cool_run[i] <= next_run;
                cool_ack[i] <= next_ack;
            end
        end
    end

    assign O_COMP_RUN = comp_run;
    assign O_COOLER1_RUN = cool_run[0];
    assign O_COOLER2_RUN = cool_run[1];
    assign O_RUNNING_ACK = run_ack;
    assign O_COOLER1_ACK = cool_ack[0];
    assign O_COOLER2_ACK = cool_ack[1];
    assign O_ALARM = alarm;
    assign O_MODE_FIXED = mode_set;
    assign O_MODE_ALTERNATE = mode_alt;

endmodule : crs_top

/* verif/crs_chk.sv */
// pin-level assertions for crs_top, bound into every instance
// assumes TICK_CYC matches the bound instance
`timescale 1ns/1ps
module crs_chk #(
    parameter int unsigned TICK_CYC = 100000
) (
    // clock, reset and inputs
    input wire logic I_CLK,
    input wire logic I_ARST_N,
    input wire logic I_RUN_LEVEL_COMMAND,
    input wire logic I_COOLER1_COMMAND,
    input wire logic I_FAULT,
    // outputs
    input wire logic O_COMP_RUN,
    input wire logic O_COOLER1_RUN,
    input wire logic O_RUNNING_ACK,
    input wire logic O_COOLER1_ACK,
    input wire logic O_COOLER2_ACK,
    input wire logic O_ALARM,
    input wire logic O_MODE_FIXED,
    input wire logic O_MODE_ALTERNATE
);
    logic [31:0] up;
    logic [31:0] next_up;
    always_comb begin
        next_up = (up == 32'hFFFFFFFF) ? up : up + 32'h1;
    end
    always_ff @(posedge I_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            up <= 32'h0;
        end else begin
            up <= next_up;
        end
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_ARST_N);
    a_ack_after_run: assert property ($rose(O_RUNNING_ACK) |-> $past(O_COMP_RUN))
        else $error("running ack without compressor");
    a_cooler_ack_gated: assert property (O_COOLER1_ACK || O_COOLER2_ACK |-> O_COMP_RUN)
        else $error("cooler ack while compressor stopped");
    a_cooler_ack_start: assert property ($rose(O_COOLER1_ACK) |-> O_COOLER1_RUN)
        else $error("cooler1 ack without cooler1 running");
    a_alt_level_stop: assert property ($fell(I_RUN_LEVEL_COMMAND) && O_MODE_ALTERNATE && O_COMP_RUN
        && O_MODE_FIXED |-> ##[1:6] !O_COMP_RUN) else $error("level drop did not stop compressor");
    a_cooler_follow: assert property (O_COMP_RUN && $fell(I_COOLER1_COMMAND) |-> ##[1:6] !O_COOLER1_ACK)
        else $error("cooler1 ack kept after command drop");
    a_mode_kept: assert property (O_MODE_FIXED && $past(O_MODE_FIXED) |-> $stable(O_MODE_ALTERNATE))
        else $error("mode changed while fixed");
    a_fault_stops: assert property (I_FAULT [*8] |-> !O_COMP_RUN && O_ALARM)
        else $error("fault did not stop and alarm");
    a_init_quiet: assert property ((up < 32'(5000 * TICK_CYC)) |-> !(O_RUNNING_ACK || O_COOLER1_ACK))
        else $error("answer during power-on blanking");
endmodule : crs_chk

bind crs_top crs_chk #(.TICK_CYC(TICK_CYC)) chk_u (.I_CLK, .I_ARST_N, .I_RUN_LEVEL_COMMAND,
    .I_COOLER1_COMMAND, .I_FAULT, .O_COMP_RUN, .O_COOLER1_RUN, .O_RUNNING_ACK, .O_COOLER1_ACK,
    .O_COOLER2_ACK, .O_ALARM, .O_MODE_FIXED, .O_MODE_ALTERNATE);

/* verif/crs_equip.sv */
// equipment-side sequence controller driving the remote inputs
// assumes one task at a time, called from the bench
`timescale 1ns/1ps
module crs_equip #(
    parameter int unsigned TICK_CYC = 100000
) (
    input wire logic clk,
    input wire logic run_ack,
    output logic run_pulse,
    output logic halt_hold,
    output logic run_level,
    output logic [1:0] cooler
);
    // start commands issued so far, all within one hour of model time
    int starts = 0;
    initial begin
        run_pulse = 1'b0;
        halt_hold = 1'b1;
        run_level = 1'b0;
        cooler = 2'h0;
    end
    task automatic set_pulse(input logic v);
        @(posedge clk) run_pulse <= v;
        starts += int'(v && !run_pulse);
    endtask : set_pulse
    task automatic set_level(input logic v);
        @(posedge clk) run_level <= v;
        starts += int'(v && !run_level);
    endtask : set_level
    task automatic set_cooler(input logic [1:0] v);
        @(posedge clk) cooler <= v;
    endtask : set_cooler
    // start released first, else the stop is ambiguous
    task automatic mom_stop;
        @(posedge clk) run_pulse <= 1'b0;
        @(posedge clk) halt_hold <= 1'b0;
    endtask : mom_stop
    // a missing answer is judged only after 8 s
    task automatic wait_ack(input logic want, output logic ok);
        int n = 0;
        while (run_ack !== want && n < 8000 * TICK_CYC) begin
            // sampled off the edge that launches the answer
            @(negedge clk);
            n++;
        end
        ok = (run_ack === want);
    endtask : wait_ack
endmodule : crs_equip

/* verif/tb_compressor_remote_sequencer.sv */
// self-checking bench: equipment model, sequencer and bound checker
// assumes ticks shortened to 2 cycles, so all figures scale by 2
`timescale 1ns/1ps
module tb_compressor_remote_sequencer;
    localparam int T = 2;
    logic clk;
    logic arst_n;
    logic fault;
    logic panel;
    logic pgood;
    logic pulse, halt, level, ok;
    logic comp, c1r, c2r, ack, a1, a2, alarm, fixed, alt;
    logic [1:0] cool;
    int num_errors = 0;
    int n_tests = 0;
    initial clk = 1'b0;
    always #5 clk = ~clk;
    crs_equip #(.TICK_CYC(T)) eq_u (.clk(clk), .run_ack(ack), .run_pulse(pulse), .halt_hold(halt),
        .run_level(level), .cooler(cool));
    crs_top #(.TICK_CYC(T)) dut_u (.I_CLK(clk), .I_ARST_N(arst_n), .I_RUN_REQUEST_PULSE(pulse),
        .I_HALT_REQUEST_HOLD(halt), .I_RUN_LEVEL_COMMAND(level), .I_COOLER1_COMMAND(cool[0]),
        .I_COOLER2_COMMAND(cool[1]), .I_FAULT(fault), .I_PANEL_RESET(panel), .I_POWER_GOOD(pgood),
        .O_COMP_RUN(comp), .O_COOLER1_RUN(c1r), .O_COOLER2_RUN(c2r), .O_RUNNING_ACK(ack),
        .O_COOLER1_ACK(a1), .O_COOLER2_ACK(a2), .O_ALARM(alarm), .O_MODE_FIXED(fixed),
        .O_MODE_ALTERNATE(alt));
    // outputs are read mid-cycle, clear of the edge updates
    task automatic at(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : at
    task automatic chk(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask : chk
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    task automatic t_power_on;
        at(60);
        chk("alarm", 1'b1, alarm);
        at(1000);
        chk("alarm", 1'b0, alarm);
        eq_u.set_level(1'b1);
        eq_u.set_cooler(2'h1);
        at(8000);
        chk("ack", 1'b0, ack);
        eq_u.wait_ack(1'b1, ok);
        chk("ack", 1'b1, ok);
        at(4);
        chk("mode_alternate", 1'b1, alt);
        chk("cooler1_run", 1'b1, c1r);
        chk("cooler1_ack", 1'b1, a1);
    endtask : t_power_on
    task automatic t_alt_coolers;
        eq_u.set_cooler(2'h2);
        at(8);
        chk("cooler1_ack", 1'b0, a1);
        chk("cooler2_ack", 1'b1, a2);
        eq_u.set_level(1'b0);
        at(8);
        chk("comp_run", 1'b0, comp);
        chk("cooler2_ack", 1'b0, a2);
        chk("cooler2_run", 1'b0, c2r);
    endtask : t_alt_coolers
    task automatic t_quick_restart;
        eq_u.set_level(1'b1);
        at(9000);
        chk("ack", 1'b0, ack);
        eq_u.wait_ack(1'b1, ok);
        chk("ack", 1'b1, ok);
    endtask : t_quick_restart
    task automatic t_dip(input int len);
        @(posedge clk) pgood <= 1'b0;
        at(20);
        chk("alarm", 1'b1, alarm);
        chk("ack", 1'b0, ack);
        at(len);
        @(posedge clk) pgood <= 1'b1;
        eq_u.wait_ack(1'b1, ok);
        chk("ack", 1'b1, ok);
    endtask : t_dip
    task automatic t_fault;
        @(posedge clk) fault <= 1'b1;
        at(10);
        chk("comp_run", 1'b0, comp);
        eq_u.set_level(1'b0);
        @(posedge clk) fault <= 1'b0;
        at(10);
        chk("alarm", 1'b1, alarm);
        @(posedge clk) panel <= 1'b1;
        @(posedge clk) panel <= 1'b0;
        at(10);
        chk("alarm", 1'b0, alarm);
    endtask : t_fault
    task automatic t_momentary;
        eq_u.set_cooler(2'h0);
        @(posedge clk) pgood <= 1'b0;
        at(4100);
        @(posedge clk) pgood <= 1'b1;
        at(10100);
        chk("mode_fixed", 1'b0, fixed);
        eq_u.set_pulse(1'b1);
        at(500);
        chk("comp_run", 1'b0, comp);
        at(200);
        chk("comp_run", 1'b1, comp);
        eq_u.set_pulse(1'b0);
        eq_u.set_level(1'b1);
        at(50);
        chk("mode_alternate", 1'b0, alt);
        chk("ack", 1'b1, ack);
        t_dip(1000);
        eq_u.mom_stop();
        at(500);
        chk("comp_run", 1'b1, comp);
        at(200);
        chk("comp_run", 1'b0, comp);
        chk("start_budget", 1'b1, eq_u.starts < 6);
    endtask : t_momentary
    initial begin
        repeat (80000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
    initial begin
        arst_n <= 1'b0;
        fault <= 1'b0;
        panel <= 1'b0;
        pgood <= 1'b1;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        t_power_on();
        t_alt_coolers();
        t_quick_restart();
        t_dip(900);
        t_fault();
        t_momentary();
        print_verdict();
    end
endmodule : tb_compressor_remote_sequencer
